// file: rtl/mal_pkg.sv
// constants shared by the maximum-address limit command block
`default_nettype none
package mal_pkg;
  // ----------------------------------------------------------------
  // register byte offsets on the wishbone slave
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FEATURE  = 8'h00; // feature_code
  localparam logic [7:0] OFF_SCOUNT   = 8'h04; // sector_count_option
  localparam logic [7:0] OFF_ADDR_LO  = 8'h08; // address_low_byte
  localparam logic [7:0] OFF_ADDR_MID = 8'h0c; // address_mid_byte
  localparam logic [7:0] OFF_ADDR_HI  = 8'h10; // address_high_byte
  localparam logic [7:0] OFF_DEVHEAD  = 8'h14; // drive_select_and_top_bits
  localparam logic [7:0] OFF_OPCODE   = 8'h18; // opcode, write launches
  localparam logic [7:0] OFF_ERROR    = 8'h1c; // error_flags
  localparam logic [7:0] OFF_STATUS   = 8'h20; // device_state_flags
  localparam logic [7:0] OFF_DATA     = 8'h24; // 16-bit data port
  localparam logic [7:0] OFF_NATIVE   = 8'h28; // native max address
  localparam logic [7:0] OFF_ID_28    = 8'h2c; // identify words 61:60
  localparam logic [7:0] OFF_ID_48    = 8'h30; // identify words 101:100
  localparam logic [7:0] OFF_ACCESS   = 8'h34; // access check address
  localparam logic [7:0] OFF_CTRL     = 8'h38; // control and state
  // ----------------------------------------------------------------
  // opcodes and feature codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_NATIVE = 8'hf8;
  localparam logic [7:0] CMD_SET_MAX     = 8'hf9;
  localparam logic [7:0] FEAT_SET_PWD    = 8'h01;
  localparam logic [7:0] FEAT_LOCK       = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK     = 8'h03;
  localparam logic [7:0] FEAT_FREEZE     = 8'h04;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_RETAIN    = 0;  // sector count: non-volatile
  localparam int BIT_LBA_MODE  = 6;  // device/head: lba mode
  localparam int BIT_ERR_ABORT = 2;  // error: abort
  localparam int BIT_ST_READY  = 6;  // status: ready
  localparam int BIT_ST_DRQ    = 3;  // status: data request
  localparam int BIT_ST_ERR    = 0;  // status: error
  localparam int BIT_C_LBA48   = 0;  // ctrl: 48-bit supported
  localparam int BIT_C_OFFSET  = 1;  // ctrl: address-offset mode
  localparam int BIT_C_EXT_HPA = 2;  // ctrl: extended area set
  localparam int BIT_C_POWER   = 3;  // ctrl: power-cycle pulse
  localparam int BIT_C_HWRST   = 4;  // ctrl: hardware-reset pulse
  localparam int BIT_C_ACC_ABT = 8;  // ctrl: last access aborted
  localparam int BIT_C_NV_USED = 9;  // ctrl: non-volatile set done
  localparam int BIT_C_PWD_OK  = 10; // ctrl: password held
  localparam int BIT_C_LOCK    = 12; // ctrl: lock state, 2 bits
  // ----------------------------------------------------------------
  // capacities, geometry and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CAP_28BIT      = 32'h0fffffff;
  localparam logic [31:0] NATIVE_RST     = 32'h0fffffff;
  localparam logic [31:0] SECT_PER_TRACK = 32'h0000003f;
  localparam logic [31:0] HEAD_COUNT     = 32'h00000010;
  localparam logic [7:0]  CHS_MAX_SECTOR = 8'h3f;
  localparam logic [3:0]  CHS_MAX_HEAD   = 4'hf;
  localparam logic [7:0]  PWD_FIRST      = 8'h01;
  localparam logic [7:0]  PWD_LAST       = 8'h10;
  localparam logic [7:0]  SECTOR_LAST    = 8'hff;
  localparam int          PWD_WORDS      = 16;
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LK_UNLOCKED = 2'b00,
    LK_LOCKED   = 2'b01,
    LK_FROZEN   = 2'b10
  } mal_lock_t;
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_DATA = 1'b1
  } mal_phase_t;
endpackage
`default_nettype wire

// file: rtl/mal_cmd.sv
// maximum-address limit command interpreter with wishbone register slave
`default_nettype none
// ------------------------------------------------------------------
// Notes on behaviour
// - f9h after read-native-max sets the limit
// - otherwise feature 01-04 picks security sub-command
// - new limit within native; beyond it aborted
// - identify words 61:60 show new limit, capped at 0fffffffh
// - second non-volatile set aborted until reset
// - locked or frozen aborts every set request
// - words 103:100 match 61:60 with 48-bit while limit is within 0fffffffh
// - 28-bit cap request restores native maximum
// - extended protected area already set aborts
// - sector count bit 0 picks retention
// - chs takes cylinder, ignores sector, head
// - lba completion returns limit in registers
// - chs completion returns 63, cylinder, head
// - set-password takes exactly one sector
// - password kept; set-password leaves unlocked
// - locked rejects all but unlock, freeze
// ------------------------------------------------------------------
module mal_cmd
  import mal_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        ack_q;                      // one-cycle answer
  logic [31:0] rdat_q;                     // registered read data
  logic        wr_go;                      // write takes effect
  logic [7:0]  feat_q, scnt_q;             // taskfile inputs
  logic [7:0]  alo_q, amid_q, ahi_q, dev_q; // address registers
  logic [7:0]  err_q;                      // error flags
  logic        err_st_q;                   // status error bit
  logic [31:0] native_q;                   // native max address
  logic [31:0] limit_q;                    // limit in force
  logic [31:0] nv_limit_q;                 // retained limit
  logic        nv_valid_q;                 // a retained limit exists
  logic        nv_used_q;                  // non-volatile set done
  logic        rnm_prev_q;                 // last command read native
  logic [2:0]  ctrl_q;                     // lba48, offset, ext area
  logic        acc_abt_q;                  // access beyond limit
  mal_lock_t   lock_q;                     // security state
  mal_phase_t  phase_q;                    // data phase of password
  logic [7:0]  wcnt_q;                     // word index in sector
  logic [15:0] pwd_q [PWD_WORDS];          // stored password
  logic        pwd_ok_q;                   // password held
  logic        cmd_go, pwr_cyc, hw_rst;    // command and reset pulses
  logic        is_set, set_abt, feat_abt;  // decode results
  logic        cmd_abt, restore;
  logic [31:0] chs_lba, req_lba, new_lim;
  logic [31:0] id28, id48;                 // identify words
  logic [31:0] new28;                      // completion value, 28-bit capped
  logic        data_wr, sector_end;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // answer in the cycle after the request, drop it the cycle after
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end
  assign wb_ack_o = ack_q;
  // writes land on the acknowledging edge only
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

  // read mux, unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdat_q <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      if (wb_adr_i == OFF_SCOUNT) begin
        rdat_q <= {24'h000000, scnt_q};
      end else if (wb_adr_i == OFF_ADDR_LO) begin
        rdat_q <= {24'h000000, alo_q};
      end else if (wb_adr_i == OFF_ADDR_MID) begin
        rdat_q <= {24'h000000, amid_q};
      end else if (wb_adr_i == OFF_ADDR_HI) begin
        rdat_q <= {24'h000000, ahi_q};
      end else if (wb_adr_i == OFF_DEVHEAD) begin
        rdat_q <= {24'h000000, dev_q};
      end else if (wb_adr_i == OFF_ERROR) begin
        rdat_q <= {24'h000000, err_q};
      end else if (wb_adr_i == OFF_STATUS) begin
        // busy never shows: every command finishes in one cycle
        rdat_q <= 32'h00000000 | (32'h1 << BIT_ST_READY)
                | (32'(phase_q == PH_DATA) << BIT_ST_DRQ)
                | (32'(err_st_q) << BIT_ST_ERR);
      end else if (wb_adr_i == OFF_NATIVE) begin
        rdat_q <= native_q;
      end else if (wb_adr_i == OFF_ID_28) begin
        rdat_q <= id28;
      end else if (wb_adr_i == OFF_ID_48) begin
        rdat_q <= id48;
      end else if (wb_adr_i == OFF_CTRL) begin
        rdat_q <= {16'h0000, 2'b00, lock_q, 1'b0, pwd_ok_q, nv_used_q,
                   acc_abt_q, 5'h00, ctrl_q};
      end else begin
        rdat_q <= 32'h00000000;
      end
    end
  end
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign cmd_go  = wr_go && (wb_adr_i == OFF_OPCODE) && (phase_q == PH_IDLE);
  assign data_wr = wr_go && (wb_adr_i == OFF_DATA) && (phase_q == PH_DATA);
  assign sector_end = data_wr && (wcnt_q == SECTOR_LAST);
  assign pwr_cyc = wr_go && (wb_adr_i == OFF_CTRL) && wb_dat_i[BIT_C_POWER];
  assign hw_rst  = wr_go && (wb_adr_i == OFF_CTRL) && wb_dat_i[BIT_C_HWRST];
  assign is_set  = (wb_dat_i[7:0] == CMD_SET_MAX) && rnm_prev_q;

  // chs: cylinder only, sector and head fields ignored
  assign chs_lba = ({16'h0000, ahi_q, amid_q} + 32'h1) * HEAD_COUNT
                   * SECT_PER_TRACK - 32'h1;
  // lba: bits spread over the four address registers
  assign req_lba = dev_q[BIT_LBA_MODE] ? {4'h0, dev_q[3:0], ahi_q, amid_q, alo_q}
                                       : chs_lba;
  // asking for the 28-bit cap on a larger drive restores native
  assign restore = (native_q > CAP_28BIT) && (req_lba == CAP_28BIT);
  assign new_lim = restore ? native_q : req_lba;
  // completion reports the new limit, not the one being replaced
  assign new28 = (new_lim > CAP_28BIT) ? CAP_28BIT : new_lim;

  // abort causes of a set request
  always_comb begin
    set_abt = 1'b0;
    if (lock_q != LK_UNLOCKED) begin
      set_abt = 1'b1;
    end else if (ctrl_q[BIT_C_EXT_HPA]) begin
      set_abt = 1'b1;
    end else if (scnt_q[BIT_RETAIN] && (nv_used_q || ctrl_q[BIT_C_OFFSET])) begin
      set_abt = 1'b1;
    end else if (!restore && (req_lba > native_q)) begin
      set_abt = 1'b1;
    end
  end

  // abort causes of a security sub-command
  always_comb begin
    case (feat_q)
      FEAT_SET_PWD: feat_abt = (lock_q != LK_UNLOCKED);
      FEAT_LOCK:    feat_abt = (lock_q != LK_UNLOCKED);
      FEAT_UNLOCK:  feat_abt = (lock_q == LK_FROZEN);
      FEAT_FREEZE:  feat_abt = (lock_q == LK_FROZEN);
      default:      feat_abt = 1'b1;
    endcase
  end
  assign cmd_abt = (wb_dat_i[7:0] == CMD_SET_MAX) && (is_set ? set_abt : feat_abt);

  // identify words follow the limit in force
  assign id28 = (limit_q > CAP_28BIT) ? CAP_28BIT : limit_q;
  assign id48 = ctrl_q[BIT_C_LBA48] ? limit_q : 32'h00000000;

  // ----------------------------------------------------------------
  // taskfile registers
  // ----------------------------------------------------------------
  // host writes, device completion overwrites the address fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feat_q <= 8'h00;
      scnt_q <= 8'h00;
      alo_q  <= 8'h00;
      amid_q <= 8'h00;
      ahi_q  <= 8'h00;
      dev_q  <= 8'h00;
    end else if (cmd_go && (wb_dat_i[7:0] == CMD_READ_NATIVE)) begin
      // read native max answers in lba layout
      alo_q  <= native_q[7:0];
      amid_q <= native_q[15:8];
      ahi_q  <= native_q[23:16];
      dev_q  <= {dev_q[7:4], native_q[27:24]};
    end else if (cmd_go && is_set && !set_abt) begin
      if (dev_q[BIT_LBA_MODE]) begin
        alo_q  <= new28[7:0];
        amid_q <= new28[15:8];
        ahi_q  <= new28[23:16];
        dev_q  <= {dev_q[7:4], new28[27:24]};
      end else begin
        alo_q <= CHS_MAX_SECTOR;
        dev_q <= {dev_q[7:4], CHS_MAX_HEAD};
      end
    end else if (wr_go) begin
      if (wb_adr_i == OFF_FEATURE) begin
        feat_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == OFF_SCOUNT) begin
        scnt_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == OFF_ADDR_LO) begin
        alo_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == OFF_ADDR_MID) begin
        amid_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == OFF_ADDR_HI) begin
        ahi_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == OFF_DEVHEAD) begin
        dev_q <= wb_dat_i[7:0];
      end
    end
  end

  // error and status error bit, only abort is ever reported
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_q    <= 8'h00;
      err_st_q <= 1'b0;
    end else if (cmd_go) begin
      err_q    <= cmd_abt ? (8'h01 << BIT_ERR_ABORT) : 8'h00;
      err_st_q <= cmd_abt;
    end else if (wr_go && (wb_adr_i == OFF_ACCESS)) begin
      err_q    <= (wb_dat_i > limit_q) ? (8'h01 << BIT_ERR_ABORT) : 8'h00;
      err_st_q <= (wb_dat_i > limit_q);
    end
  end

  // ----------------------------------------------------------------
  // limit, retention and configuration
  // ----------------------------------------------------------------
  // read-native-max must come directly before the set request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rnm_prev_q <= 1'b0;
    end else if (pwr_cyc || hw_rst) begin
      rnm_prev_q <= 1'b0;
    end else if (cmd_go) begin
      rnm_prev_q <= (wb_dat_i[7:0] == CMD_READ_NATIVE);
    end
  end

  // limit in force; a power cycle brings back the retained one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      limit_q    <= NATIVE_RST;
      nv_limit_q <= NATIVE_RST;
      nv_valid_q <= 1'b0;
      nv_used_q  <= 1'b0;
    end else if (pwr_cyc) begin
      limit_q   <= nv_valid_q ? nv_limit_q : native_q;
      nv_used_q <= 1'b0;
    end else if (hw_rst) begin
      nv_used_q <= 1'b0;
    end else if (cmd_go && is_set && !set_abt) begin
      limit_q <= new_lim;
      if (scnt_q[BIT_RETAIN]) begin
        nv_limit_q <= new_lim;
        nv_valid_q <= 1'b1;
        nv_used_q  <= 1'b1;
      end
    end
  end

  // native capacity, feature straps and last access result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      native_q  <= NATIVE_RST;
      ctrl_q    <= 3'h0;
      acc_abt_q <= 1'b0;
    end else if (wr_go) begin
      if (wb_adr_i == OFF_NATIVE) begin
        native_q <= wb_dat_i;
      end else if (wb_adr_i == OFF_CTRL) begin
        ctrl_q <= wb_dat_i[2:0];
      end else if (wb_adr_i == OFF_ACCESS) begin
        acc_abt_q <= (wb_dat_i > limit_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // security state and password sector
  // ----------------------------------------------------------------
  // lock state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= LK_UNLOCKED;
    end else if (pwr_cyc) begin
      lock_q <= LK_UNLOCKED;
    end else if (sector_end) begin
      lock_q <= LK_UNLOCKED;
    end else if (cmd_go && !is_set && !cmd_abt
                 && (wb_dat_i[7:0] == CMD_SET_MAX)) begin
      case (feat_q)
        FEAT_LOCK:   lock_q <= LK_LOCKED;
        FEAT_UNLOCK: lock_q <= LK_UNLOCKED;
        FEAT_FREEZE: lock_q <= LK_FROZEN;
        default:     lock_q <= lock_q;
      endcase
    end
  end

  // data phase: one sector of 256 words, then back to idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= PH_IDLE;
      wcnt_q  <= 8'h00;
    end else begin
      case (phase_q)
        PH_IDLE: begin
          wcnt_q <= 8'h00;
          if (cmd_go && !is_set && !cmd_abt && (wb_dat_i[7:0] == CMD_SET_MAX)
              && (feat_q == FEAT_SET_PWD)) begin
            phase_q <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (sector_end) begin
            phase_q <= PH_IDLE;
          end
          if (data_wr) begin
            wcnt_q <= wcnt_q + 8'h01;
          end
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // password words kept until the next power cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwd_ok_q <= 1'b0;
    end else if (pwr_cyc) begin
      pwd_ok_q <= 1'b0;
    end else if (sector_end) begin
      pwd_ok_q <= 1'b1;
    end
  end
  for (genvar gi = 0; gi < PWD_WORDS; gi++) begin : g_pwd
    // word gi of the password sits at sector word gi + 1
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pwd_q[gi] <= 16'h0000;
      end else if (pwr_cyc) begin
        pwd_q[gi] <= 16'h0000;
      end else if (data_wr && (wcnt_q == PWD_FIRST + 8'(gi))) begin
        pwd_q[gi] <= wb_dat_i[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [8:0] dcnt_q; // words since the data phase began
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dcnt_q <= 9'h000;
    end else begin
      dcnt_q <= (phase_q == PH_IDLE) ? 9'h000 : dcnt_q + 9'(data_wr);
    end
  end

  AST_SET_LIMIT: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && !set_abt && !pwr_cyc |=> limit_q == $past(new_lim))
    else $error("limit not taken from accepted request");
  AST_LOCK_ABORT: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && lock_q != LK_UNLOCKED |=> err_st_q && limit_q == $past(limit_q))
    else $error("set request accepted while locked");
  AST_NV_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && nv_used_q && scnt_q[BIT_RETAIN] |=> err_q[BIT_ERR_ABORT])
    else $error("second non-volatile set not aborted");
  AST_ID28: assert property (@(posedge clk) disable iff (!rst_b)
    limit_q <= CAP_28BIT |-> id28 == limit_q)
    else $error("identify 61:60 differs from limit");
  AST_ID48: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_q[BIT_C_LBA48] && limit_q <= CAP_28BIT |-> id48 == id28)
    else $error("identify 103:100 differs from 61:60");
  AST_RESTORE: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && restore && !set_abt && !pwr_cyc
    |=> limit_q == native_q && id28 == CAP_28BIT)
    else $error("28-bit cap request did not restore native");
  AST_EXT_HPA: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && ctrl_q[BIT_C_EXT_HPA] |=> $stable(limit_q) && err_st_q)
    else $error("set accepted over extended area");
  AST_ABORT_BITS: assert property (@(posedge clk) disable iff (!rst_b)
    err_st_q |-> err_q == (8'h01 << BIT_ERR_ABORT))
    else $error("abort reported with wrong error bits");
  AST_SECTOR_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    phase_q == PH_DATA ##1 phase_q == PH_IDLE |-> $past(dcnt_q) == 9'h0ff)
    else $error("password sector not 256 words");
  AST_PWD_UNLOCK: assert property (@(posedge clk) disable iff (!rst_b)
    sector_end && !pwr_cyc |=> lock_q == LK_UNLOCKED && pwd_ok_q)
    else $error("set-password did not leave unlocked");
  AST_CHS_DONE: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && !set_abt && !dev_q[BIT_LBA_MODE] |=> alo_q == CHS_MAX_SECTOR)
    else $error("chs completion sector not 63");
  AST_LBA_DONE: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && !set_abt && dev_q[BIT_LBA_MODE] |=> limit_q > CAP_28BIT
    || {dev_q[3:0], ahi_q, amid_q, alo_q} == limit_q[27:0])
    else $error("lba completion differs from new limit");
  AST_PWD_WORD: assert property (@(posedge clk) disable iff (!rst_b)
    data_wr && wcnt_q == PWD_FIRST |=> pwd_q[0] == $past(wb_dat_i[15:0]))
    else $error("first password word not stored");
  AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  COV_SET_OK: cover property (@(posedge clk) disable iff (!rst_b)
    cmd_go && is_set && !set_abt);
  COV_PWD_DONE: cover property (@(posedge clk) disable iff (!rst_b) sector_end);
  COV_FROZEN: cover property (@(posedge clk) disable iff (!rst_b)
    lock_q == LK_FROZEN);
  COV_ACC_ABT: cover property (@(posedge clk) disable iff (!rst_b)
    acc_abt_q);
endmodule
`default_nettype wire

// file: tb/mal_host.sv
// host model driving the taskfile registers over wishbone
`default_nettype none
module mal_host
  import mal_pkg::*;
(
  // bus master side
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [31:0]      dat,
  input  wire logic [31:0] din,
  input  wire logic        ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] q; // data of the last read
  initial {cyc, stb, we, adr, dat} = '0;
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d); // held until ack
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = din;
    {cyc, stb, we, dat} <= {3'b000, ~d}; // released data no longer valid
    @(posedge clk);
  endtask
  task put_addr(input logic [27:0] a, input logic lba); // address over four regs
    xfer(1'b1, OFF_ADDR_LO, {24'h0, a[7:0]});
    xfer(1'b1, OFF_ADDR_MID, {24'h0, a[15:8]});
    xfer(1'b1, OFF_ADDR_HI, {24'h0, a[23:16]});
    xfer(1'b1, OFF_DEVHEAD, {24'h0, 1'b1, lba, 2'b10, a[27:24]});
  endtask
  task send_pwd(input logic [15:0] p); // whole sector, password in words 1-16
    for (int i = 0; i < 256; i++) begin
      xfer(1'b1, OFF_DATA, (i >= 1 && i <= PWD_WORDS) ? {16'h0, p ^ 16'(i)} : 32'h0);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// bench for the maximum-address limit command block
`default_nettype none
module tb_top
  import mal_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst_b = 1'b0; // clock, reset held low at start
  logic        cyc, stb, we, ack;        // bus handshake
  logic [7:0]  adr;                      // byte address
  logic [31:0] wd, rd;                   // write and read data
  int          error_cnt = 0, n_tests = 0, cyc_cnt = 0;
  always #2.5 clk = ~clk;
  mal_host h (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(wd), .din(rd),
    .ack(ack));
  mal_cmd uut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack));
  task end_sim();
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) error_cnt++;
    if (s !== e) $display("wrong value at %0t: %h expected %h", $time, s, e);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    h.xfer(1'b0, a, 32'h0);
    chk(h.q, e);
  endtask
  // optional read-native, then feature, retention, address, set opcode
  task cmd(input logic arm, nv, lba, input logic [7:0] f, input logic [27:0] a);
    if (arm) h.xfer(1'b1, OFF_OPCODE, {24'h0, CMD_READ_NATIVE});
    h.xfer(1'b1, OFF_FEATURE, {24'h0, f});
    h.xfer(1'b1, OFF_SCOUNT, {31'h0, nv});
    h.put_addr(a, lba);
    h.xfer(1'b1, OFF_OPCODE, {24'h0, CMD_SET_MAX});
  endtask
  always @(posedge clk) begin // hang guard
    cyc_cnt++;
    if (cyc_cnt == 5000) error_cnt++;
    if (cyc_cnt == 5000) end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    cmd(1'b0, 1'b0, 1'b1, 8'h05, 28'h0);
    rc(OFF_STATUS, 32'h41);
    h.xfer(1'b1, OFF_CTRL, 32'h1);
    cmd(1'b1, 1'b0, 1'b1, 8'h00, 28'h0123456);
    rc(OFF_ID_48, 32'h0123456);
    rc(OFF_ADDR_LO, 32'h56);
    h.xfer(1'b1, OFF_ACCESS, 32'h0123457);
    rc(OFF_ERROR, 32'h4);
    h.xfer(1'b1, OFF_ACCESS, 32'h0123456);
    rc(OFF_ERROR, 32'h0);
    h.xfer(1'b1, OFF_CTRL, 32'h5);
    cmd(1'b1, 1'b0, 1'b1, 8'h00, 28'h0000100);
    rc(OFF_ERROR, 32'h4);
    h.xfer(1'b1, OFF_CTRL, 32'h1);
    cmd(1'b0, 1'b0, 1'b1, FEAT_LOCK, 28'h0);
    rc(OFF_CTRL, 32'h1001);
    cmd(1'b1, 1'b0, 1'b1, 8'h00, 28'h0000100);
    rc(OFF_ERROR, 32'h4);
    cmd(1'b0, 1'b0, 1'b1, FEAT_UNLOCK, 28'h0);
    rc(OFF_CTRL, 32'h1);
    cmd(1'b0, 1'b0, 1'b1, FEAT_LOCK, 28'h0);
    cmd(1'b0, 1'b0, 1'b1, FEAT_FREEZE, 28'h0);
    cmd(1'b0, 1'b0, 1'b1, FEAT_UNLOCK, 28'h0);
    rc(OFF_ERROR, 32'h4);
    cmd(1'b1, 1'b0, 1'b1, 8'h00, 28'h0000100);
    rc(OFF_ID_28, 32'h0123456);
    h.xfer(1'b1, OFF_CTRL, 32'h9);
    cmd(1'b0, 1'b0, 1'b1, FEAT_SET_PWD, 28'h0);
    rc(OFF_STATUS, 32'h48);
    h.send_pwd(16'hbeef);
    rc(OFF_CTRL, 32'h401);
    h.xfer(1'b1, OFF_NATIVE, 32'h1000);
    cmd(1'b1, 1'b0, 1'b1, 8'h00, 28'h0002000);
    rc(OFF_ERROR, 32'h4);
    cmd(1'b1, 1'b1, 1'b1, 8'h00, 28'h0000800);
    cmd(1'b1, 1'b1, 1'b1, 8'h00, 28'h0000400);
    rc(OFF_ERROR, 32'h4);
    rc(OFF_ID_28, 32'h800);
    h.xfer(1'b1, OFF_CTRL, 32'h11);
    cmd(1'b1, 1'b1, 1'b1, 8'h00, 28'h0000400);
    rc(OFF_ID_28, 32'h400);
    h.xfer(1'b1, OFF_CTRL, 32'h9);
    rc(OFF_ID_28, 32'h400);
    rc(OFF_CTRL, 32'h1);
    h.xfer(1'b1, OFF_NATIVE, 32'h20000000);
    cmd(1'b1, 1'b0, 1'b1, 8'h00, 28'hfffffff);
    rc(OFF_ID_48, 32'h20000000);
    rc(OFF_ID_28, 32'h0fffffff);
    cmd(1'b1, 1'b0, 1'b0, 8'h00, 28'h5000277);
    rc(OFF_ID_28, 32'hbcf);
    rc(OFF_ADDR_LO, 32'h3f);
    rc(OFF_ADDR_MID, 32'h02);
    rc(OFF_DEVHEAD, 32'haf);
    end_sim();
  end
endmodule
`default_nettype wire
